// ---- src/mmvl_map.vh ----
// Register map, field layout, codes and timing for the modulation matrix and pitch LFO
`ifndef MMVL_MAP_VH
`define MMVL_MAP_VH

`define MMVL_CLK_HZ            10000000
`define MMVL_UPDATE_PERIOD_US  100

`define MMVL_REG_CTRL          8'h00
`define MMVL_REG_LFO_PARAM     8'h04
`define MMVL_REG_LFO_DEPTH     8'h08
`define MMVL_REG_ROUTE_SEL     8'h0C
`define MMVL_REG_ROUTE_CFG     8'h10
`define MMVL_REG_STATUS        8'h14
`define MMVL_REG_LFO_MON       8'h18

`define MMVL_CTRL_WAVE_LSB     0
`define MMVL_CTRL_TRIG_LSB     4
`define MMVL_PAR_SPEED_LSB     0
`define MMVL_PAR_DELAY_LSB     8
`define MMVL_PAR_LEVEL_LSB     16
`define MMVL_DEP_WHEEL_LSB     0
`define MMVL_DEP_AT_LSB        8
`define MMVL_DEP_PITCH_LSB     16
`define MMVL_DEP_FILT_LSB      24
`define MMVL_RT_SRC_LSB        0
`define MMVL_RT_DEST_LSB       8
`define MMVL_RT_LEVEL_LSB      16
`define MMVL_RT_GATE_BIT       24
`define MMVL_RT_QUANT_BIT      25

`define MMVL_RST_WAVE          3'h0
`define MMVL_RST_TRIG          2'h0
`define MMVL_RST_SEVEN         7'h00
`define MMVL_RST_BYTE          8'h00

`define MMVL_PARAM_MAX         7'h63
`define MMVL_LEVEL_MAX         8'h63
`define MMVL_LEVEL_MIN         8'h9D
`define MMVL_ROUTES            6
`define MMVL_GATED_ROUTES      3
`define MMVL_QUANT_STEP        16'h02FA

`define MMVL_TRIG_MONO         2'h0
`define MMVL_TRIG_POLY         2'h1
`define MMVL_TRIG_KEY_MONO     2'h2
`define MMVL_TRIG_KEY_POLY     2'h3

`define MMVL_WAVE_SINE         3'h0
`define MMVL_WAVE_TRI          3'h1
`define MMVL_WAVE_SQUARE       3'h2
`define MMVL_WAVE_SAW_UP       3'h3
`define MMVL_WAVE_SAW_DOWN     3'h4
`define MMVL_WAVE_RAND_BI      3'h5
`define MMVL_WAVE_NOISE        3'h6
`define MMVL_WAVE_RAND_POS     3'h7

`define MMVL_SRC_CHAN_COUNT    5'h08
`define MMVL_SRC_VOICE_END     5'h10
`define MMVL_SRC_PITCH_LFO     5'h10
`define MMVL_SRC_AFTERTOUCH    3'h0
`define MMVL_SRC_WHEEL         3'h1

`define MMVL_DEST_PITCH        3'h0
`define MMVL_DEST_CUTOFF       3'h1
`define MMVL_DEST_LFO_SPEED    3'h4
`define MMVL_DEST_LFO_AMT      3'h5
`define MMVL_DEST_LFO_DELAY    3'h6
`define MMVL_DEST_PORTA        3'h7

`endif

// ---- src/mmvl_mod_matrix_lfo.v ----
// Six-way modulation matrix with per-voice pitch LFO, APB register slave
`timescale 1ns/1ps
`include "mmvl_map.vh"

// Overview of operation
// - Routing level spans -99..+99; zero level contributes nothing.
// - Negative level gives same magnitude with inverted sign.
// - Level 72 at full-scale source moves pitch exactly one octave.
// - Gate control exists only on routings one to three.
// - Gated routing passes modulation only while a key is held.
// - Quantize control exists only on routings four to six.
// - Quantize steps output in semitones; otherwise linear with source.
// - Portamento modulation silent unless base portamento rate is at least one.
// - Pitch LFO acts only via nonzero pitch depth or as routing source.
// - Eight waveshapes; both saws and positive random are unipolar.
// - Speed 00..99, larger is faster.
// - Delay 00..99 sets fade-in time after note start; larger is slower.
// - Each voice has an LFO; mono mode keeps all voices phase-locked.
// - Mono mode ignores per-voice sources when modulating LFO speed.
// - Poly mode runs each voice's LFO independently, own speed.
// - Key-mono restarts the shared phase on every new note.
// - Key-poly restarts a voice's phase on its new note.
// - LFO amount is base level plus wheel and aftertouch terms.
// - Wheel depth -99..99 scales wheel term; amount clamps at zero.
// - Aftertouch depth -99..99 scales pressure term, raising or lowering.
// - Filter LFO acts only via nonzero filter depth; it is not a routing source.
// - Cutoff saturates at maximum, masking further filter LFO.
// - Six independent routings, alike except gate and quantize, edited one at a time.
// - Zero level means disabled; enabled state readable as status.
module mmvl_mod_matrix_lfo #(
    parameter VOICES = 4
) (
    input  wire                    ref_clk,
    input  wire                    rst,
    input  wire [7:0]              paddr,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    input  wire [63:0]             chanSrc,
    input  wire [VOICES*64-1:0]    voiceSrc,
    input  wire [VOICES-1:0]       voiceTrig,
    input  wire                    keysHeld,
    input  wire [VOICES*8-1:0]     filterLfo,
    input  wire [127:0]            destBase,
    output reg  [VOICES*128-1:0]   destOut,
    output reg  [VOICES*8-1:0]     lfoOut,
    output wire                    updateTick
);

    localparam integer UPDATE_CYCLES = `MMVL_UPDATE_PERIOD_US * (`MMVL_CLK_HZ / 1000000);
    localparam [9:0]   DIV_LAST      = UPDATE_CYCLES[9:0] - 10'h001;
    localparam signed [15:0] QSTEP   = `MMVL_QUANT_STEP;

    reg  [9:0]        divCnt_q;
    reg  [2:0]        wave_q;
    reg  [1:0]        trig_q;
    reg  [6:0]        speed_q;
    reg  [6:0]        delay_q;
    reg  [6:0]        level_q;
    reg  signed [7:0] wheelDepth_q;
    reg  signed [7:0] atDepth_q;
    reg  signed [7:0] pitchDepth_q;
    reg  signed [7:0] filtDepth_q;
    reg  [2:0]        routeSel_q;
    reg  [4:0]        routeSrc_q   [0:5];
    reg  [2:0]        routeDest_q  [0:5];
    reg  signed [7:0] routeLvl_q   [0:5];
    reg               routeGate_q  [0:5];
    reg               routeQuant_q [0:5];
    reg  [15:0]       lfsr_q;
    reg  [15:0]       gPhase_q;
    reg  [5:0]        routeOn;
    reg  [31:0]       rdMux;
    reg               mapped;
    reg  signed [19:0] monoSpdAcc;
    reg  signed [15:0] mc;
    reg  [6:0]        monoSpeed;
    reg  signed [11:0] chanAmt;
    reg  signed [15:0] whlProd;
    reg  signed [15:0] atProd;
    reg  signed [15:0] amtSum;
    wire              apbWrite;
    wire              anyKeyMono;
    // Monitor shows the amount after the floor at zero
    wire [11:0]       amtMon = chanAmt[11] ? 12'h000 : chanAmt;
    integer           i;
    integer           j;
    integer           k;

    function [6:0] clampParam;
        input [6:0] x;
        begin
            clampParam = (x > `MMVL_PARAM_MAX) ? `MMVL_PARAM_MAX : x;
        end
    endfunction

    function signed [7:0] clampLevel;
        input signed [7:0] x;
        begin
            if (x > $signed(`MMVL_LEVEL_MAX))
                clampLevel = `MMVL_LEVEL_MAX;
            else if (x < $signed(`MMVL_LEVEL_MIN))
                clampLevel = `MMVL_LEVEL_MIN;
            else
                clampLevel = x;
        end
    endfunction

    function signed [7:0] srcVal;
        input [4:0]  sel;
        input [63:0] chan;
        input [63:0] vsrc;
        input [7:0]  lfo;
        begin
            if (sel < `MMVL_SRC_CHAN_COUNT)
                srcVal = chan[{sel[2:0], 3'h0} +: 8];
            else if (sel < `MMVL_SRC_VOICE_END)
                srcVal = vsrc[{sel[2:0], 3'h0} +: 8];
            else if (sel == `MMVL_SRC_PITCH_LFO)
                srcVal = lfo;
            else
                srcVal = 8'h00;
        end
    endfunction

    // Product of 127 full scale and level 72 is 9144, twelve steps of 762
    function signed [15:0] routeContrib;
        input signed [7:0] src;
        input signed [7:0] lvl;
        input              gateOn;
        input              quantOn;
        input              held;
        reg signed [15:0]  c;
        begin
            c = src * lvl;
            if (gateOn && !held)
                c = 16'h0000;
            if (quantOn)
                c = (c / QSTEP) * QSTEP;
            routeContrib = c;
        end
    endfunction

    // Squared speed spreads 00..99 over about 0.15 Hz to 23 Hz
    function [15:0] speedInc;
        input [6:0] s;
        reg   [13:0] sq;
        begin
            sq = s * s;
            speedInc = {8'h00, sq[13:6]} + 16'h0001;
        end
    endfunction

    assign updateTick = (divCnt_q == DIV_LAST);
    assign apbWrite   = psel & penable & pwrite & mapped;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~mapped;
    assign anyKeyMono = |voiceTrig & (trig_q == `MMVL_TRIG_KEY_MONO);

    always @(posedge ref_clk) begin
        if (rst)
            divCnt_q <= 10'h000;
        else if (updateTick)
            divCnt_q <= 10'h000;
        else
            divCnt_q <= divCnt_q + 10'h001;
    end

    always @* begin
        mapped = 1'b1;
        rdMux  = 32'h00000000;
        case (paddr)
            `MMVL_REG_CTRL:      rdMux = {26'h0, trig_q, 1'b0, wave_q};
            `MMVL_REG_LFO_PARAM: rdMux = {9'h0, level_q, 1'b0, delay_q, 1'b0, speed_q};
            `MMVL_REG_LFO_DEPTH: rdMux = {filtDepth_q, pitchDepth_q, atDepth_q, wheelDepth_q};
            `MMVL_REG_ROUTE_SEL: rdMux = {29'h0, routeSel_q};
            `MMVL_REG_ROUTE_CFG: begin
                if (routeSel_q < `MMVL_ROUTES)
                    rdMux = {6'h0, routeQuant_q[routeSel_q], routeGate_q[routeSel_q],
                             routeLvl_q[routeSel_q], 5'h0, routeDest_q[routeSel_q],
                             3'h0, routeSrc_q[routeSel_q]};
            end
            `MMVL_REG_STATUS:    rdMux = {26'h0, routeOn};
            `MMVL_REG_LFO_MON:   rdMux = {12'h000, amtMon, lfoOut[7:0]};
            default:             mapped = 1'b0;
        endcase
    end

    always @* begin
        for (j = 0; j < `MMVL_ROUTES; j = j + 1)
            routeOn[j] = (routeLvl_q[j] != 8'h00);
    end

    // Read data is captured in the setup phase so the access phase answers at once
    always @(posedge ref_clk) begin
        if (rst)
            prdata <= 32'h00000000;
        else if (psel && !penable)
            prdata <= rdMux;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            wave_q       <= `MMVL_RST_WAVE;
            trig_q       <= `MMVL_RST_TRIG;
            speed_q      <= `MMVL_RST_SEVEN;
            delay_q      <= `MMVL_RST_SEVEN;
            level_q      <= `MMVL_RST_SEVEN;
            wheelDepth_q <= `MMVL_RST_BYTE;
            atDepth_q    <= `MMVL_RST_BYTE;
            pitchDepth_q <= `MMVL_RST_BYTE;
            filtDepth_q  <= `MMVL_RST_BYTE;
            routeSel_q   <= 3'h0;
            for (i = 0; i < `MMVL_ROUTES; i = i + 1) begin
                routeSrc_q[i]   <= 5'h00;
                routeDest_q[i]  <= 3'h0;
                routeLvl_q[i]   <= `MMVL_RST_BYTE;
                routeGate_q[i]  <= 1'b0;
                routeQuant_q[i] <= 1'b0;
            end
        end else if (apbWrite) begin
            case (paddr)
                `MMVL_REG_CTRL: begin
                    wave_q <= pwdata[`MMVL_CTRL_WAVE_LSB +: 3];
                    trig_q <= pwdata[`MMVL_CTRL_TRIG_LSB +: 2];
                end
                `MMVL_REG_LFO_PARAM: begin
                    speed_q <= clampParam(pwdata[`MMVL_PAR_SPEED_LSB +: 7]);
                    delay_q <= clampParam(pwdata[`MMVL_PAR_DELAY_LSB +: 7]);
                    level_q <= clampParam(pwdata[`MMVL_PAR_LEVEL_LSB +: 7]);
                end
                `MMVL_REG_LFO_DEPTH: begin
                    wheelDepth_q <= clampLevel(pwdata[`MMVL_DEP_WHEEL_LSB +: 8]);
                    atDepth_q    <= clampLevel(pwdata[`MMVL_DEP_AT_LSB +: 8]);
                    pitchDepth_q <= clampLevel(pwdata[`MMVL_DEP_PITCH_LSB +: 8]);
                    filtDepth_q  <= clampLevel(pwdata[`MMVL_DEP_FILT_LSB +: 8]);
                end
                `MMVL_REG_ROUTE_SEL: routeSel_q <= pwdata[2:0];
                `MMVL_REG_ROUTE_CFG: begin
                    if (routeSel_q < `MMVL_ROUTES) begin
                        routeSrc_q[routeSel_q]   <= pwdata[`MMVL_RT_SRC_LSB +: 5];
                        routeDest_q[routeSel_q]  <= pwdata[`MMVL_RT_DEST_LSB +: 3];
                        routeLvl_q[routeSel_q]   <= clampLevel(pwdata[`MMVL_RT_LEVEL_LSB +: 8]);
                        routeGate_q[routeSel_q]  <= pwdata[`MMVL_RT_GATE_BIT]
                                                    & (routeSel_q < `MMVL_GATED_ROUTES);
                        routeQuant_q[routeSel_q] <= pwdata[`MMVL_RT_QUANT_BIT]
                                                    & (routeSel_q >= `MMVL_GATED_ROUTES);
                    end
                end
                default: ;
            endcase
        end
    end

    // Shared speed for mono modes sees only channel-wide sources
    always @* begin
        monoSpdAcc = 20'h00000;
        mc         = 16'h0000;
        for (k = 0; k < `MMVL_ROUTES; k = k + 1) begin
            mc = routeContrib(chanSrc[{routeSrc_q[k][2:0], 3'h0} +: 8], routeLvl_q[k],
                              routeGate_q[k], routeQuant_q[k], keysHeld);
            if (routeDest_q[k] == `MMVL_DEST_LFO_SPEED && routeSrc_q[k] < `MMVL_SRC_CHAN_COUNT)
                monoSpdAcc = monoSpdAcc + {{4{mc[15]}}, mc};
        end
        if ($signed({13'h0, speed_q}) + (monoSpdAcc >>> 7) > $signed(20'h00063))
            monoSpeed = `MMVL_PARAM_MAX;
        else if ($signed({13'h0, speed_q}) + (monoSpdAcc >>> 7) < $signed(20'h00000))
            monoSpeed = 7'h00;
        else
            monoSpeed = speed_q + monoSpdAcc[13:7];
        whlProd = $signed(chanSrc[{`MMVL_SRC_WHEEL, 3'h0} +: 8]) * wheelDepth_q;
        atProd  = $signed(chanSrc[{`MMVL_SRC_AFTERTOUCH, 3'h0} +: 8]) * atDepth_q;
        amtSum  = $signed({9'h000, level_q}) + whlProd / 16'sd128 + atProd / 16'sd128;
        chanAmt = amtSum[11:0];
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            lfsr_q   <= 16'hACE1;
            gPhase_q <= 16'h0000;
        end else begin
            if (updateTick)
                lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            if (anyKeyMono)
                gPhase_q <= 16'h0000;
            else if (updateTick)
                gPhase_q <= gPhase_q + speedInc(monoSpeed);
        end
    end

    genvar v;
    generate
        for (v = 0; v < VOICES; v = v + 1) begin : gVoice
            reg  [15:0]        vPhase_q;
            reg  [15:0]        fade_q;
            reg                prevMsb_q;
            reg  [7:0]         randHold_q;
            reg  [127:0]       outV;
            reg  signed [19:0] t;
            reg  signed [19:0] sum;
            reg  signed [19:0] tSpd;
            reg  signed [19:0] tAmt;
            reg  signed [19:0] tDly;
            reg  signed [15:0] c;
            reg  signed [15:0] base;
            reg  [6:0]         effSpeed;
            reg  [6:0]         effDelay;
            reg  [7:0]         amt;
            reg  [15:0]        ph;
            reg  [29:0]        sq;
            reg  signed [7:0]  wav;
            reg  signed [25:0] scaled;
            reg  signed [19:0] lo;
            reg  signed [19:0] x;
            wire [63:0]        vs = voiceSrc[v*64 +: 64];
            integer            r;
            integer            d;

            always @* begin
                outV = 128'h0;
                tSpd = 20'h00000;
                tAmt = 20'h00000;
                tDly = 20'h00000;
                c    = 16'h0000;
                for (d = 0; d < 8; d = d + 1) begin
                    t = 20'h00000;
                    for (r = 0; r < `MMVL_ROUTES; r = r + 1) begin
                        c = routeContrib(srcVal(routeSrc_q[r], chanSrc, vs, lfoOut[v*8 +: 8]),
                                         routeLvl_q[r], routeGate_q[r], routeQuant_q[r],
                                         keysHeld);
                        if (routeDest_q[r] == d[2:0])
                            t = t + {{4{c[15]}}, c};
                    end
                    base = destBase[d*16 +: 16];
                    sum  = {{4{base[15]}}, base} + t;
                    if (d[2:0] == `MMVL_DEST_PITCH)
                        sum = sum + $signed(lfoOut[v*8 +: 8]) * pitchDepth_q;
                    if (d[2:0] == `MMVL_DEST_CUTOFF)
                        sum = sum + $signed(filterLfo[v*8 +: 8]) * filtDepth_q;
                    lo = (d[2:0] == `MMVL_DEST_PITCH) ? 20'hF8000 : 20'h00000;
                    if (sum > $signed(20'h07FFF))
                        sum = 20'h07FFF;
                    else if (sum < lo)
                        sum = lo;
                    if (d[2:0] == `MMVL_DEST_PORTA && base <= $signed(16'h0000))
                        sum = 20'h00000;
                    outV[d*16 +: 16] = sum[15:0];
                    if (d[2:0] == `MMVL_DEST_LFO_SPEED) tSpd = t;
                    if (d[2:0] == `MMVL_DEST_LFO_AMT)   tAmt = t;
                    if (d[2:0] == `MMVL_DEST_LFO_DELAY) tDly = t;
                end
                x = $signed({13'h0, speed_q}) + (tSpd >>> 7);
                effSpeed = (x > $signed(20'h00063)) ? `MMVL_PARAM_MAX :
                           (x < $signed(20'h00000)) ? 7'h00 : x[6:0];
                x = $signed({13'h0, delay_q}) + (tDly >>> 7);
                effDelay = (x > $signed(20'h00063)) ? `MMVL_PARAM_MAX :
                           (x < $signed(20'h00000)) ? 7'h00 : x[6:0];
                x = $signed({{8{chanAmt[11]}}, chanAmt}) + (tAmt >>> 7);
                amt = (x > $signed(20'h000FF)) ? 8'hFF :
                      (x < $signed(20'h00000)) ? 8'h00 : x[7:0];
                ph = (trig_q[0]) ? vPhase_q : gPhase_q;
                sq = {15'h0, ph[14:0]} * (30'h00008000 - {15'h0, ph[14:0]});
                case (wave_q)
                    `MMVL_WAVE_SINE: begin
                        wav = (sq[28:21] > 8'h7F) ? 8'h7F : sq[28:21];
                        if (ph[15])
                            wav = -wav;
                    end
                    `MMVL_WAVE_TRI:
                        wav = ph[15] ? 8'sh7F - {1'b0, ph[14:8]} : {1'b0, ph[14:8]} - 8'sh7F;
                    `MMVL_WAVE_SQUARE:    wav = ph[15] ? 8'h81 : 8'h7F;
                    `MMVL_WAVE_SAW_UP:    wav = {1'b0, ph[15:9]};
                    `MMVL_WAVE_SAW_DOWN:  wav = 8'h7F - {1'b0, ph[15:9]};
                    `MMVL_WAVE_RAND_BI:   wav = randHold_q;
                    `MMVL_WAVE_NOISE:     wav = lfsr_q[7:0];
                    `MMVL_WAVE_RAND_POS:  wav = {1'b0, randHold_q[6:0]};
                    default:              wav = 8'h00;
                endcase
                scaled = wav * $signed({1'b0, amt}) * $signed({1'b0, fade_q[15:8]});
            end

            // Restart wins over a tick landing in the same cycle
            always @(posedge ref_clk) begin
                if (rst) begin
                    vPhase_q   <= 16'h0000;
                    fade_q     <= 16'h0000;
                    prevMsb_q  <= 1'b0;
                    randHold_q <= 8'h00;
                    lfoOut[v*8 +: 8]     <= 8'h00;
                    destOut[v*128 +: 128] <= 128'h0;
                end else begin
                    destOut[v*128 +: 128] <= outV;
                    if (voiceTrig[v] && trig_q == `MMVL_TRIG_KEY_POLY)
                        vPhase_q <= 16'h0000;
                    else if (updateTick)
                        vPhase_q <= vPhase_q + speedInc(effSpeed);
                    if (voiceTrig[v])
                        fade_q <= (effDelay == 7'h00) ? 16'hFFFF : 16'h0000;
                    else if (updateTick)
                        fade_q <= (fade_q > 16'hFFFF - {9'h0, 7'h64 - effDelay}) ?
                                  16'hFFFF : fade_q + {9'h0, 7'h64 - effDelay};
                    if (updateTick) begin
                        prevMsb_q <= ph[15];
                        if (prevMsb_q && !ph[15])
                            randHold_q <= lfsr_q[15:8];
                        lfoOut[v*8 +: 8] <= scaled[23:16];
                    end
                end
            end
        end
    endgenerate

endmodule

// ---- tb/mmvl_chk_sva.sv ----
// Port-level assertions for the modulation matrix and pitch LFO block
`timescale 1ns/1ps
module mmvl_chk #(parameter VOICES = 4) (
    input wire                   ref_clk,
    input wire                   rst,
    input wire                   psel,
    input wire                   penable,
    input wire [31:0]            prdata,
    input wire                   pslverr,
    input wire [127:0]           destBase,
    input wire [VOICES*128-1:0]  destOut,
    input wire [VOICES*8-1:0]    lfoOut,
    input wire                   updateTick
);
    reg [10:0] tickCnt;
    // Mirrors the divider, both cleared by the same reset
    always @(posedge ref_clk) begin
        if (rst) tickCnt <= 11'h000;
        else tickCnt <= updateTick ? 11'h000 : tickCnt + 11'h001;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_tickGap; updateTick |=> !updateTick [*8]; endproperty
    a_tickGap: assert property (p_tickGap) else $error("tick too soon");
    property p_tickPeriod; tickCnt <= 11'h3E7; endproperty
    a_tickPeriod: assert property (p_tickPeriod) else $error("tick late");
    property p_lfoHold; !updateTick |=> $stable(lfoOut); endproperty
    a_lfoHold: assert property (p_lfoHold) else $error("lfo moved off tick");
    property p_errPhase; pslverr |-> psel && penable; endproperty
    a_errPhase: assert property (p_errPhase) else $error("error outside access");
    property p_prHold; !(psel && !penable) |=> $stable(prdata); endproperty
    a_prHold: assert property (p_prHold) else $error("read data moved");
    property p_floor; !(destOut[31] | destOut[47] | destOut[63] | destOut[79] | destOut[95]
        | destOut[111] | destOut[127]); endproperty
    a_floor: assert property (p_floor) else $error("dest below floor");
    property p_porta; $signed(destBase[127:112]) <= $signed(16'h0000)
        |=> destOut[127:112] == 16'h0000; endproperty
    a_porta: assert property (p_porta) else $error("porta moved");
    property p_rstVal; $fell(rst) |-> ~|lfoOut && ~|prdata && ~|destOut; endproperty
    a_rstVal: assert property (p_rstVal) else $error("reset values");
    c_tick: cover property (updateTick);
    c_err: cover property (pslverr);
    c_porta: cover property (destBase[127:112] != 16'h0000 && destOut[127:112] != 16'h0000);
endmodule
bind mmvl_mod_matrix_lfo mmvl_chk #(.VOICES(VOICES)) uChk (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .prdata(prdata), .pslverr(pslverr), .destBase(destBase),
    .destOut(destOut), .lfoOut(lfoOut), .updateTick(updateTick));

// ---- tb/tb_top.sv ----
// Self-checking bench for the modulation matrix and pitch LFO block
`timescale 1ns/1ps
`include "mmvl_map.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    logic         ref_clk, rst, psel, penable, pwrite, pready, pslverr, keysHeld, updateTick;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rdv, lfoOut;
    logic [63:0]  chanSrc;
    logic [3:0]   voiceTrig;
    logic [127:0] destBase;
    logic [511:0] destOut;
    int           error_cnt = 0;
    int           tests_run = 0;
    mmvl_mod_matrix_lfo #(.VOICES(4)) DUT (.ref_clk(ref_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chanSrc(chanSrc), .voiceSrc(256'h0),
        .voiceTrig(voiceTrig), .keysHeld(keysHeld), .filterLfo(32'h0), .destBase(destBase),
        .destOut(destOut), .lfoOut(lfoOut), .updateTick(updateTick));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task give_verdict;
        $display("compares %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic er);
        int n;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin error_cnt++; give_verdict(); end
        rdv = prdata;
        `CHK("slverr", er, pslverr)
        {psel, penable} <= 2'b00;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d, 1'b0); endtask
    task rd(input logic [7:0] a); apb(1'b0, a, 32'h0, 1'b0); endtask
    task automatic tick;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            voiceTrig <= 4'h0;
            n++;
        end while (updateTick !== 1'b1 && n < 1100);
        if (n >= 1100) begin error_cnt++; give_verdict(); end
    endtask
    function automatic logic [31:0] cfg(input logic [7:0] l, input logic [2:0] dst,
            input logic g, input logic q);
        return {6'h00, q, g, l, 5'h00, dst, 3'h0, 5'h02};
    endfunction
    // Output is registered one edge after the input change
    task peek(input logic [15:0] e, input int d);
        repeat (2) @(posedge ref_clk);
        `CHK("dest", e, destOut[d*16 +: 16])
    endtask
    task route(input logic [2:0] s, input logic [31:0] c, input logic [15:0] e, input int d);
        wr(`MMVL_REG_ROUTE_SEL, {29'h0, s});
        wr(`MMVL_REG_ROUTE_CFG, c);
        peek(e, d);
    endtask
    initial begin
        {rst, psel, penable, pwrite, keysHeld} = 5'h10;
        {paddr, pwdata, chanSrc, voiceTrig, destBase} = 236'h0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 28; a += 4) begin
            rd(a[7:0]);
            `CHK("reset value", 32'h0, rdv)
        end
        apb(1'b0, 8'h1C, 32'h0, 1'b1);
        `CHK("unmapped", 32'h0, rdv)
        $display("register test done");
        {chanSrc, keysHeld} <= {64'h7F0000, 1'b1};
        route(3'h0, cfg(8'h48, 3'h0, 1'b0, 1'b0), 16'h23B8, 0);
        route(3'h0, cfg(8'hB8, 3'h0, 1'b0, 1'b0), 16'hDC48, 0);
        route(3'h0, cfg(8'h00, 3'h0, 1'b0, 1'b0), 16'h0000, 0);
        rd(`MMVL_REG_STATUS);
        `CHK("status", 32'h0, rdv)
        route(3'h0, cfg(8'h48, 3'h0, 1'b1, 1'b1), 16'h23B8, 0);
        rd(`MMVL_REG_ROUTE_CFG);
        `CHK("gate bits", 2'b01, rdv[25:24])
        keysHeld <= 1'b0;
        peek(16'h0000, 0);
        {keysHeld, destBase[15:0]} <= {1'b1, 16'h7000};
        peek(16'h7FFF, 0);
        destBase <= 128'h0;
        route(3'h0, cfg(8'h7F, 3'h0, 1'b0, 1'b0), 16'h311D, 0);
        rd(`MMVL_REG_ROUTE_CFG);
        `CHK("level clamp", 8'h63, rdv[23:16])
        route(3'h3, cfg(8'h0A, 3'h1, 1'b1, 1'b1), 16'h02FA, 1);
        rd(`MMVL_REG_ROUTE_CFG);
        `CHK("quant bits", 2'b10, rdv[25:24])
        route(3'h3, cfg(8'h0A, 3'h1, 1'b0, 1'b0), 16'h04F6, 1);
        route(3'h4, cfg(8'h32, 3'h7, 1'b0, 1'b0), 16'h0000, 7);
        destBase[127:112] <= 16'h0001;
        peek(16'h18CF, 7);
        rd(`MMVL_REG_STATUS);
        `CHK("status", 32'h19, rdv)
        $display("routing test done");
        wr(`MMVL_REG_LFO_PARAM, 32'h000A0000);
        wr(`MMVL_REG_LFO_DEPTH, 32'h0);
        tick;
        rd(`MMVL_REG_LFO_MON);
        `CHK("amount", 12'h00A, rdv[19:8])
        chanSrc <= 64'h7F7F7F;
        wr(`MMVL_REG_LFO_DEPTH, 32'h00009D9D);
        tick;
        rd(`MMVL_REG_LFO_MON);
        `CHK("amount floor", 12'h000, rdv[19:8])
        wr(`MMVL_REG_LFO_PARAM, 32'h00630063);
        wr(`MMVL_REG_LFO_DEPTH, 32'h00630000);
        for (int i = 0; i < 8; i++) begin
            wr(`MMVL_REG_CTRL, {26'h0, i[1:0], 1'b0, i[2:0]});
            rd(`MMVL_REG_CTRL);
            `CHK("ctrl", {26'h0, i[1:0], 1'b0, i[2:0]}, rdv)
            voiceTrig <= 4'hF;
            tick;
            tick;
        end
        wr(`MMVL_REG_LFO_DEPTH, 32'h0);
        tick;
        peek(16'h311D, 0);
        $display("lfo test done");
        give_verdict();
    end
endmodule
